/* core/idw_pkg.sv */
// Purpose: constants, register map and state types of the identify record
// Assumes: 16-bit record words, 32-bit register port
// Notes:   word contents are fixed here, geometry comes from registers
package idw_pkg;

  // record shape
  localparam int unsigned IDW_WORDS        = 256;
  localparam logic [7:0]  IDW_LAST_WORD    = 8'hff;

  // general configuration word choices
  localparam logic [15:0] W0_STANDARD      = 16'h848a;
  localparam logic [15:0] W0_ALT_RETIRED   = 16'h044a;
  localparam logic [15:0] W0_ALT_CLEAN     = 16'h0040;
  localparam logic [1:0]  W0_SEL_STANDARD  = 2'h0;
  localparam logic [1:0]  W0_SEL_RETIRED   = 2'h1;
  localparam logic [1:0]  W0_SEL_CLEAN     = 2'h2;
  localparam int          W0_NONREMOV_BIT  = 6;

  // fixed record words
  localparam logic [15:0] BUF_TYPE_WORD    = 16'h0002;
  localparam logic [15:0] MULT_MAX_WORD    = 16'h8001;
  localparam logic [15:0] CAPS_WORD        = 16'h0b00;
  localparam logic [15:0] PIO_MODE_WORD    = 16'h0200;
  localparam logic [15:0] VALID_WORD       = 16'h0007;
  localparam logic [15:0] ADV_PIO_WORD     = 16'h0003;
  localparam logic [15:0] FEATURE_WORD     = 16'h706b;
  localparam logic [7:0]  MULT_VALID_BYTE  = 8'h01;
  localparam logic [7:0]  SPACE_CHAR       = 8'h20;

  // cycle times reported in nanoseconds
  localparam int          MDMA_CYCLE_NS    = 120;
  localparam int          PIO_CYCLE_NS     = 120;
  localparam logic [15:0] MDMA_CYCLE_WORD  = 16'(MDMA_CYCLE_NS);
  localparam logic [15:0] PIO_CYCLE_WORD   = 16'(PIO_CYCLE_NS);

  // register byte addresses
  localparam logic [7:0]  REG_CONFIG       = 8'h00;
  localparam logic [7:0]  REG_DEF_GEOM     = 8'h04;
  localparam logic [7:0]  REG_DEF_SPT      = 8'h08;
  localparam logic [7:0]  REG_CUR_GEOM     = 8'h0c;
  localparam logic [7:0]  REG_CUR_SPT      = 8'h10;
  localparam logic [7:0]  REG_TOTAL        = 8'h14;
  localparam logic [7:0]  REG_MULT         = 8'h18;
  localparam logic [7:0]  REG_DMA_SEL      = 8'h1c;
  localparam logic [7:0]  REG_SN_USER      = 8'h20;
  localparam logic [7:0]  REG_STATUS       = 8'h24;

  // field positions
  localparam int          CFG_ROOT_BIT     = 2;
  localparam int          STAT_ACTIVE_BIT  = 8;

  // reset values
  localparam logic [15:0] RST_CYL          = 16'h0400;
  localparam logic [15:0] RST_HEADS        = 16'h0010;
  localparam logic [15:0] RST_SPT          = 16'h003f;
  localparam logic [31:0] RST_TOTAL        = 32'h000fc000;
  localparam logic [7:0]  RST_MULT         = 8'h00;
  localparam logic [2:0]  RST_DMA_SEL      = 3'h0;
  localparam logic [79:0] RST_SN_USER      = {10{SPACE_CHAR}};

  // streaming states, one-hot
  typedef enum logic [1:0] {
    IDW_IDLE = 2'b01,
    IDW_SEND = 2'b10
  } idw_fsm_t;

  // whole state of the block
  typedef struct packed {
    idw_fsm_t    fsm;
    logic [7:0]  ptr;
    logic [15:0] data;
    logic [31:0] rdata;
    logic [1:0]  w0_sel;
    logic        root;
    logic [15:0] def_cyl;
    logic [15:0] def_heads;
    logic [15:0] def_spt;
    logic [15:0] cur_cyl;
    logic [15:0] cur_heads;
    logic [15:0] cur_spt;
    logic [31:0] total;
    logic [7:0]  mult;
    logic [2:0]  dma_sel;
    logic [79:0] sn_user;
  } idw_state_t;

endpackage

/* core/idw_identify_data_words.sv */
// Purpose: builds and streams the 256-word drive identification record
// Assumes: all inputs synchronous to clk, one clock domain
// Notes:   words are formed on the fly, no record memory is held
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: standard configuration word reads 848AH
// R2: alternates 044AH or 0040H may be chosen
// R3: word 0 top nibble only 8H or 0H
// R4: word 0 retired bits 11-8 are 0H or 4H
// R5: word 0 low bits 00H or 0AH, bits 2,0 zero
// R6: root storage mode sets word 0 bit 6
// R7: words 7-8 give total sector count
// R8: serial: user bytes left, unique ID right
// R9: word 20 reports dual-ported buffer 0002H
// R10: word 47 allows one sector per interrupt
// R11: capabilities: bit 13 clear; 11,9,8 set
// R12: word 53 validates 54-58, 64-70, 88
// R13: words 57-58 are cylinders times heads times sectors
// R14: word 59 high byte 01H, low byte multiple count
// R15: only one DMA mode selected at once
// R16: DMA mode 2 support implies modes 0, 1
// R17: word 64 reports PIO modes 3 and 4
// R18: words 65-66 report 120 ns DMA cycle
// R19: faster DMA may be throttled by request drop
// R20: words 67-68 report 0078H PIO cycle
// R21: feature-set words report 706BH
// R22: record goes out as 256 ascending words
module idw_identify_data_words #(
  parameter logic [2:0]   MDMA_SUPPORT = 3'h7,            // supported dma modes
  parameter logic [63:0]  FW_REV       = {8{8'h20}},      // arbitrary default
  parameter logic [319:0] MODEL_TEXT   = {40{8'h20}}      // arbitrary default
) (
  input  wire logic        clk,        // 40 mhz core clock
  input  wire logic        srst,       // synchronous reset, high
  input  wire logic [7:0]  reg_addr,   // register byte address
  input  wire logic [31:0] reg_wdata,  // register write data
  input  wire logic        reg_wr,     // register write strobe
  input  wire logic        reg_rd,     // register read strobe
  output logic      [31:0] reg_rdata,  // read data, cycle after strobe
  input  wire logic [79:0] uid,        // factory unique id, ten ascii bytes
  input  wire logic        id_start,   // identify command accepted
  input  wire logic        id_next,    // host took the current word
  output logic      [15:0] id_data,    // current record word
  output logic             id_valid    // record stream in progress
);
  import idw_pkg::*;

  idw_state_t s_ff;       // registered state
  idw_state_t nxt_s;      // next state
  logic [31:0] cap;       // current capacity in sectors
  logic [2:0]  dma_sup;   // supported mask after closure

  // current capacity, low 32 bits of the three-way product
  // a large geometry overflows 32 bits; the host only sees the low 32 bits of the 48-bit product
  // see R13
  always_comb begin
    logic [47:0] prod;
    prod = 48'h0;
    prod = {s_ff.cur_cyl, 32'h0} >> 32;
    prod = prod * {32'h0, s_ff.cur_heads};
    prod = prod * {32'h0, s_ff.cur_spt};
    cap  = prod[31:0];
  end

  // a mode 2 capable part is always mode 0 and 1 capable
  // see R16
  assign dma_sup = MDMA_SUPPORT[2] ? (MDMA_SUPPORT | 3'h3) : MDMA_SUPPORT;

  // general configuration word, choice plus root storage flag
  function automatic logic [15:0] idw_word0(input logic [1:0] sel,
                                            input logic       root);
    logic [15:0] w;
    w = W0_STANDARD;                       // see R1
    case (sel)
      W0_SEL_RETIRED: w = W0_ALT_RETIRED;  // see R2
      W0_SEL_CLEAN:   w = W0_ALT_CLEAN;    // see R2
      default:        w = W0_STANDARD;     // reserved codes fall back
    endcase
    // hosts booting from this unit in true ide mode need non-removable
    if (root) begin
      w[W0_NONREMOV_BIT] = 1'b1;           // see R6
    end
    // every choice keeps the top nibble at 8h or 0h, see R3
    // retired bits 11-8 stay at 0h or 4h, see R4
    // low field stays 00h or 0ah, bits 2 and 0 clear, see R5
    return w;
  endfunction

  // one record word by index
  function automatic logic [15:0] idw_word(input logic [7:0] idx,
                                           input idw_state_t s,
                                           input logic [79:0]  id,
                                           input logic [31:0]  c,
                                           input logic [2:0]   sup);
    logic [7:0]  k;
    logic [15:0] w;
    k = 8'h0;
    w = 16'h0;
    case (idx) inside
      8'd0:  w = idw_word0(s.w0_sel, s.root);
      8'd1:  w = s.def_cyl;
      8'd3:  w = s.def_heads;
      8'd6:  w = s.def_spt;
      8'd7:  w = s.total[31:16];                      // see R7
      8'd8:  w = s.total[15:0];                       // see R7
      [8'd10:8'd14]: begin
        k = idx - 8'd10;
        w = s.sn_user[79-16*k -: 16];                 // see R8
      end
      [8'd15:8'd19]: begin
        k = idx - 8'd15;
        w = id[79-16*k -: 16];                        // see R8
      end
      8'd20: w = BUF_TYPE_WORD;                       // see R9
      [8'd23:8'd26]: begin
        k = idx - 8'd23;
        w = FW_REV[63-16*k -: 16];
      end
      [8'd27:8'd46]: begin
        k = idx - 8'd27;
        w = MODEL_TEXT[319-16*k -: 16];
      end
      8'd47: w = MULT_MAX_WORD;                       // see R10
      8'd49: w = CAPS_WORD;                           // see R11
      8'd51: w = PIO_MODE_WORD;
      8'd53: w = VALID_WORD;                          // see R12
      8'd54: w = s.cur_cyl;
      8'd55: w = s.cur_heads;
      8'd56: w = s.cur_spt;
      8'd57: w = c[15:0];                             // see R13
      8'd58: w = c[31:16];                            // see R13
      8'd59: w = {MULT_VALID_BYTE, s.mult};           // see R14
      8'd60: w = s.total[15:0];
      8'd61: w = s.total[31:16];
      8'd63: w = {5'h0, s.dma_sel, 5'h0, sup};        // see R15
      8'd64: w = ADV_PIO_WORD;                        // see R17
      8'd65: w = MDMA_CYCLE_WORD;                     // see R18
      // shorter host cycles are throttled by the transfer engine
      8'd66: w = MDMA_CYCLE_WORD;                     // see R18 see R19
      8'd67: w = PIO_CYCLE_WORD;                      // see R20
      8'd68: w = PIO_CYCLE_WORD;                      // see R20
      [8'd82:8'd84]: w = FEATURE_WORD;                // see R21
      default: w = 16'h0;                             // reserved words
    endcase
    return w;
  endfunction

  // next state: register port, record stream
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.rdata = 32'h0;                  // read data live one cycle only
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        REG_CONFIG: begin
          nxt_s.w0_sel = reg_wdata[1:0];
          nxt_s.root   = reg_wdata[CFG_ROOT_BIT];
        end
        REG_DEF_GEOM: begin
          nxt_s.def_cyl   = reg_wdata[15:0];
          nxt_s.def_heads = reg_wdata[31:16];
        end
        REG_DEF_SPT: nxt_s.def_spt = reg_wdata[15:0];
        REG_CUR_GEOM: begin
          nxt_s.cur_cyl   = reg_wdata[15:0];
          nxt_s.cur_heads = reg_wdata[31:16];
        end
        REG_CUR_SPT: nxt_s.cur_spt = reg_wdata[15:0];
        REG_TOTAL:   nxt_s.total   = reg_wdata;
        REG_MULT:    nxt_s.mult    = reg_wdata[7:0];     // see R14
        REG_DMA_SEL: begin
          // a new selection replaces the old one, never adds to it
          case (reg_wdata[1:0])
            2'h0:    nxt_s.dma_sel = 3'h1;               // see R15
            2'h1:    nxt_s.dma_sel = 3'h2;               // see R15
            2'h2:    nxt_s.dma_sel = 3'h4;               // see R15
            default: nxt_s.dma_sel = 3'h0;               // no mode
          endcase
        end
        REG_SN_USER: begin
          // one character per write, index in bits 11:8
          for (int i = 0; i < 10; i++) begin
            if (reg_wdata[11:8] == 4'(i)) begin
              nxt_s.sn_user[79-8*i -: 8] = reg_wdata[7:0];  // see R8
            end
          end
        end
        default: ;                                 // unmapped and read-only, ignored
      endcase
    end
    // register reads
    if (reg_rd) begin
      case (reg_addr)
        REG_CONFIG:   nxt_s.rdata = {29'h0, s_ff.root, s_ff.w0_sel};
        REG_DEF_GEOM: nxt_s.rdata = {s_ff.def_heads, s_ff.def_cyl};
        REG_DEF_SPT:  nxt_s.rdata = {16'h0, s_ff.def_spt};
        REG_CUR_GEOM: nxt_s.rdata = {s_ff.cur_heads, s_ff.cur_cyl};
        REG_CUR_SPT:  nxt_s.rdata = {16'h0, s_ff.cur_spt};
        REG_TOTAL:    nxt_s.rdata = s_ff.total;
        REG_MULT:     nxt_s.rdata = {24'h0, s_ff.mult};
        REG_DMA_SEL:  nxt_s.rdata = {29'h0, s_ff.dma_sel};
        REG_STATUS:   nxt_s.rdata = {23'h0, s_ff.fsm == IDW_SEND, s_ff.ptr};
        default:      nxt_s.rdata = 32'h0;  // unmapped and write-only
      endcase
    end
    // record stream
    case (s_ff.fsm)
      IDW_IDLE: begin
        if (id_start) begin
          nxt_s.fsm  = IDW_SEND;                                // see R22
          nxt_s.ptr  = 8'h0;
          nxt_s.data = idw_word(8'h0, s_ff, uid, cap, dma_sup);
        end
      end
      IDW_SEND: begin
        // a repeated identify while sending is ignored
        if (id_next) begin
          if (s_ff.ptr == IDW_LAST_WORD) begin
            nxt_s.fsm  = IDW_IDLE;
            nxt_s.ptr  = 8'h0;
            nxt_s.data = 16'h0;
          end else begin
            nxt_s.ptr  = s_ff.ptr + 8'h1;                       // see R22
            nxt_s.data = idw_word(s_ff.ptr + 8'h1, s_ff, uid, cap, dma_sup);
          end
        end
      end
      default: begin
        nxt_s.fsm = IDW_IDLE;             // illegal code recovers
      end
    endcase
    // reset values
    if (srst) begin
      nxt_s.fsm       = IDW_IDLE;
      nxt_s.ptr       = 8'h0;
      nxt_s.data      = 16'h0;
      nxt_s.rdata     = 32'h0;
      nxt_s.w0_sel    = W0_SEL_STANDARD;
      nxt_s.root      = 1'b0;
      nxt_s.def_cyl   = RST_CYL;
      nxt_s.def_heads = RST_HEADS;
      nxt_s.def_spt   = RST_SPT;
      nxt_s.cur_cyl   = RST_CYL;
      nxt_s.cur_heads = RST_HEADS;
      nxt_s.cur_spt   = RST_SPT;
      nxt_s.total     = RST_TOTAL;
      nxt_s.mult      = RST_MULT;         // multiple commands invalid
      nxt_s.dma_sel   = RST_DMA_SEL;
      nxt_s.sn_user   = RST_SN_USER;      // user serial defaults to spaces
    end
  end

  // state register
  // no reset branch here: reset is folded into the next-state logic
  always_ff @(posedge clk) begin
    s_ff <= nxt_s;
  end

  // reg_rdata and id_data straight from flops, id_valid decoded from the state flops
  assign reg_rdata = s_ff.rdata;
  assign id_data   = s_ff.data;
  assign id_valid  = (s_ff.fsm == IDW_SEND);

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic w0_out;   // word 0 on the data port
  assign w0_out = id_valid && (s_ff.ptr == 8'h0);

  w0_standard_a: assert property ( // see R1
    w0_out && s_ff.w0_sel == W0_SEL_STANDARD && !s_ff.root
      |-> id_data == W0_STANDARD)
    else $error("word 0 not standard value");
  w0_alternate_a: assert property ( // see R2
    w0_out && s_ff.w0_sel == W0_SEL_RETIRED |-> id_data == W0_ALT_RETIRED)
    else $error("word 0 not retired alternate");
  w0_flag_nibble_a: assert property ( // see R3
    w0_out |-> id_data[15:12] == 4'h8 || id_data[15:12] == 4'h0)
    else $error("word 0 configuration flag illegal");
  w0_retired_a: assert property ( // see R4
    w0_out |-> id_data[11:8] == 4'h0 || id_data[11:8] == 4'h4)
    else $error("word 0 retired bits illegal");
  w0_low_bits_a: assert property ( // see R5
    w0_out |-> (id_data[5:0] == 6'h00 || id_data[5:0] == 6'h0a)
               && !id_data[2] && !id_data[0])
    else $error("word 0 low bits illegal");
  root_nonremov_a: assert property ( // see R6
    w0_out && s_ff.root |-> id_data[W0_NONREMOV_BIT])
    else $error("root storage without bit 6");
  caps_word_a: assert property ( // see R11
    id_valid && s_ff.ptr == 8'd49
      |-> !id_data[13] && id_data[11] && id_data[9] && id_data[8])
    else $error("capabilities word wrong");
  capacity_a: assert property ( // see R13
    id_valid && s_ff.ptr == 8'd57 |-> id_data == cap[15:0])
    else $error("capacity low word wrong");
  mult_word_a: assert property ( // see R14
    id_valid && s_ff.ptr == 8'd59 |-> id_data == {8'h01, s_ff.mult})
    else $error("multiple sector word wrong");
  dma_onehot_a: assert property ( // see R15
    $onehot0(s_ff.dma_sel))
    else $error("more than one dma mode selected");
  dma_support_a: assert property ( // see R16
    id_valid && s_ff.ptr == 8'd63 && id_data[2] |-> id_data[1:0] == 2'h3)
    else $error("dma mode 2 without lower modes");
  pio_cycle_a: assert property ( // see R20
    id_valid && (s_ff.ptr == 8'd67 || s_ff.ptr == 8'd68)
      |-> id_data == 16'h0078)
    else $error("pio cycle word wrong");
  start_word_a: assert property ( // see R22
    !id_valid && id_start |=> id_valid && s_ff.ptr == 8'h0)
    else $error("identify did not start at word 0");
  step_order_a: assert property ( // see R22
    id_valid && id_next && s_ff.ptr != IDW_LAST_WORD
      |=> id_valid && s_ff.ptr == $past(s_ff.ptr) + 8'h1)
    else $error("record words out of order");
  last_word_a: assert property ( // see R22
    id_valid && id_next && s_ff.ptr == IDW_LAST_WORD |=> !id_valid)
    else $error("stream did not end after word 255");
  read_window_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");

  // fixed words: constants the host relies on, checked while they stand
  buf_type_a: assert property ( // see R9
    id_valid && s_ff.ptr == 8'd20 |-> id_data == 16'h0002)
    else $error("buffer type word wrong");
  mult_max_a: assert property ( // see R10
    id_valid && s_ff.ptr == 8'd47 |-> id_data[7:0] == 8'h01)
    else $error("multiple sector maximum not one");
  valid_bits_a: assert property ( // see R12
    id_valid && s_ff.ptr == 8'd53 |-> id_data[2:0] == 3'h7)
    else $error("translation valid bits missing");
  adv_pio_a: assert property ( // see R17
    id_valid && s_ff.ptr == 8'd64
      |-> id_data[7:2] == 6'h00 && id_data[1:0] == 2'h3)
    else $error("advanced pio word wrong");
  dma_cycle_a: assert property ( // see R18
    id_valid && (s_ff.ptr == 8'd65 || s_ff.ptr == 8'd66)
      |-> id_data == 16'h0078)
    else $error("dma cycle word wrong");
  feature_word_a: assert property ( // see R21
    id_valid && s_ff.ptr >= 8'd82 && s_ff.ptr <= 8'd84
      |-> id_data == 16'h706b)
    else $error("feature set word wrong");
  // words and registers that carry register and pin contents
  total_words_a: assert property ( // see R7
    id_valid && s_ff.ptr == 8'd7 |-> id_data == s_ff.total[31:16])
    else $error("sector count high word wrong");
  unique_id_a: assert property ( // see R8
    id_valid && s_ff.ptr >= 8'd15 && s_ff.ptr <= 8'd19
      |-> id_data == uid[79-16*(s_ff.ptr-8'd15) -: 16])
    else $error("unique id word wrong");
  dma_select_a: assert property ( // see R15
    reg_wr && reg_addr == REG_DMA_SEL && reg_wdata[1:0] == 2'h2
      |=> s_ff.dma_sel == 3'h4)
    else $error("mode 2 select left other modes set");
  status_read_a: assert property ( // see R22
    reg_rd && reg_addr == REG_STATUS
      |=> reg_rdata[STAT_ACTIVE_BIT] == $past(id_valid))
    else $error("status streaming bit wrong");

  full_record_c: cover property (
    id_valid && id_next && s_ff.ptr == IDW_LAST_WORD);
  root_mode_c: cover property (w0_out && s_ff.root);
  dma_change_c: cover property (
    $past(s_ff.dma_sel) == 3'h2 && s_ff.dma_sel == 3'h4);
  stall_c: cover property (id_valid && !id_next ##1 id_valid && !id_next);
  status_read_c: cover property (reg_rd && reg_addr == REG_STATUS);

endmodule

`default_nettype wire

/* tb/idw_host_model.sv */
// Purpose: host side that pulls the identify record out word by word
// Assumes: word 0 stands one cycle after id_start, one word per id_next
// Notes:   slow mode stalls two cycles before taking each word
`timescale 1ns/1ps
`default_nettype none
module idw_host_model (
  input  wire logic        clk,       // core clock
  input  wire logic        go,        // bench asks for one record
  input  wire logic        slow,      // stall before each word
  input  wire logic [15:0] id_data,   // word from the block
  input  wire logic        id_valid,  // stream in progress
  output logic             id_start,  // identify command pulse
  output logic             id_next,   // word taken pulse
  output logic             done       // whole record captured
);
  logic [15:0] rec [256];  // captured words
  logic        vld [256];  // valid level seen with each word
  logic        end_v;      // valid level after the last word
  int          n;          // word counter

  // one fetch per go; the host always reads all 256 words
  initial begin
    id_start = 1'b0;
    id_next  = 1'b0;
    done     = 1'b0;
    end_v    = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        done     <= 1'b0;
        id_start <= 1'b1;
        @(posedge clk);
        #1;
        id_start <= 1'b0;
        for (n = 0; n < 256; n++) begin
          // a stall checks that the word stands until it is taken
          if (slow) begin
            id_next <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
          end
          rec[n] = id_data;
          vld[n] = id_valid;
          id_next <= 1'b1;
          @(posedge clk);
          #1;
        end
        id_next <= 1'b0;
        end_v = id_valid;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/identify_data_words_test.sv */
// Purpose: self-checking bench for the identify record block
// Assumes: register map and word layout as handed over by the designer
// Notes:   every fetched record is compared word by word with a shadow
`timescale 1ns/1ps
`default_nettype none
module identify_data_words_test;
  import idw_pkg::*;
  logic        clk, srst, reg_wr, reg_rd, go, slow;  // bench drives
  logic        id_start, id_next, id_valid, done;    // handshake
  logic [7:0]  reg_addr;                             // register address
  logic [31:0] reg_wdata, reg_rdata;                 // register data
  logic [79:0] uid;                                  // factory id, fixed
  logic [15:0] id_data;                              // record word
  int          failures, compares;                   // score
  // shadow of what the record should hold
  logic [1:0]  sel;
  logic        root;
  logic [15:0] dcyl, dhd, dspt, ccyl, chd, cspt;
  logic [31:0] total;
  logic [7:0]  mult;
  logic [2:0]  dsel;
  logic [79:0] sn;

  idw_identify_data_words dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .uid(uid), .id_start(id_start),
    .id_next(id_next), .id_data(id_data), .id_valid(id_valid));
  idw_host_model host (.clk(clk), .go(go), .slow(slow), .id_data(id_data),
    .id_valid(id_valid), .id_start(id_start), .id_next(id_next),
    .done(done));

  // 40 mhz clock
  always #12.5 clk = ~clk;

  // expected word, built from the shadow values
  function automatic logic [15:0] exp_word(input int n);
    logic [31:0] cap;
    logic [15:0] w0;
    cap = {16'h0, ccyl} * {16'h0, chd} * {16'h0, cspt};
    w0 = (sel == 2'h1) ? 16'h044a : (sel == 2'h2) ? 16'h0040 : 16'h848a;
    if (root) begin
      w0 = w0 | 16'h0040;
    end
    case (n)
      0: exp_word = w0;
      1: exp_word = dcyl;
      3: exp_word = dhd;
      6: exp_word = dspt;
      7, 61: exp_word = total[31:16];
      8, 60: exp_word = total[15:0];
      10, 11, 12, 13, 14: exp_word = sn[79-16*(n-10) -: 16];
      15, 16, 17, 18, 19: exp_word = uid[79-16*(n-15) -: 16];
      20: exp_word = 16'h0002;
      47: exp_word = 16'h8001;
      49: exp_word = 16'h0b00;
      51: exp_word = 16'h0200;
      53: exp_word = 16'h0007;
      54: exp_word = ccyl;
      55: exp_word = chd;
      56: exp_word = cspt;
      57: exp_word = cap[15:0];
      58: exp_word = cap[31:16];
      59: exp_word = {8'h01, mult};
      63: exp_word = {5'h00, dsel, 5'h00, 3'h7};
      64: exp_word = 16'h0003;
      65, 66, 67, 68: exp_word = 16'h0078;
      82, 83, 84: exp_word = 16'h706b;
      default: exp_word = (n >= 23 && n <= 46) ? 16'h2020 : 16'h0000;
    endcase
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one write cycle, strobe dropped before the next request
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // one read cycle; data is looked at in the single cycle it stands
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask

  // pull one record through the host model and compare all of it
  task automatic fetch(input logic s);
    int k;
    logic [31:0] d;
    slow <= s;
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    rd(REG_STATUS, d);
    chk("status while streaming", 32'h0000_0100, d);
    for (k = 0; k < 3000 && done !== 1'b1; k++) begin
      @(posedge clk);
    end
    if (done !== 1'b1) begin
      failures++;
      $display("wrong value record done expected 1 seen %b", done);
      close_out();
    end
    for (k = 0; k < 256; k++) begin
      chk("record word", 32'(exp_word(k)), 32'(host.rec[k]));
      chk("word valid", 32'h1, 32'(host.vld[k]));
    end
    chk("valid after word 255", 32'h0, 32'(host.end_v));
    chk("data after word 255", 32'h0, 32'(id_data));
  endtask

  // register reset values, write-only and unmapped places
  task automatic t_reset;
    logic [31:0] d;
    rd(REG_CONFIG, d);
    chk("config", 32'h0, d);
    rd(REG_DEF_GEOM, d);
    chk("default geometry", 32'h0010_0400, d);
    rd(REG_TOTAL, d);
    chk("total", 32'h000f_c000, d);
    rd(REG_MULT, d);
    chk("multiple count", 32'h0, d);
    rd(REG_DMA_SEL, d);
    chk("dma select", 32'h0, d);
    rd(REG_SN_USER, d);
    chk("serial read", 32'h0, d);
    rd(8'h40, d);
    chk("unmapped read", 32'h0, d);
    rd(REG_STATUS, d);
    chk("status idle", 32'h0, d);
    fetch(1'b0);
    $display("test reset values and default record done");
  endtask

  // every word 0 choice, with and without root storage
  task automatic t_config;
    int s;
    int r;
    for (s = 0; s < 4; s++) begin
      for (r = 0; r < 2; r++) begin
        sel  = 2'(s);
        root = 1'(r);
        wr(REG_CONFIG, {29'h0, root, sel});
        fetch(1'b0);
      end
    end
    sel  = 2'h0;
    root = 1'b0;
    wr(REG_CONFIG, 32'h0);
    $display("test configuration word done");
  endtask

  // geometry, counts, serial bytes and each dma selection
  task automatic t_fields;
    logic [31:0] d;
    int m;
    ccyl  = 16'h1234;
    chd   = 16'h000f;
    cspt  = 16'h003f;
    total = 32'h1234_5678;
    mult  = 8'h01;
    dcyl  = 16'h0222;
    dhd   = 16'h0008;
    dspt  = 16'h0020;
    wr(REG_DEF_GEOM, {dhd, dcyl});
    wr(REG_DEF_SPT, {16'h0, dspt});
    rd(REG_DEF_SPT, d);
    chk("default sectors", {16'h0, dspt}, d);
    wr(REG_CUR_GEOM, {chd, ccyl});
    wr(REG_CUR_SPT, {16'h0, cspt});
    wr(REG_TOTAL, total);
    wr(REG_MULT, {24'h0, mult});
    wr(REG_SN_USER, 32'h0000_0041);
    wr(REG_SN_USER, 32'h0000_095a);
    wr(REG_SN_USER, 32'h0000_0a33);
    sn[79:72] = 8'h41;
    sn[7:0]   = 8'h5a;
    for (m = 0; m < 4; m++) begin
      dsel = (m == 3) ? 3'h0 : 3'(1 << m);
      wr(REG_DMA_SEL, 32'(m));
      rd(REG_DMA_SEL, d);
      chk("dma select", {29'h0, dsel}, d);
      fetch(m == 1);
    end
    $display("test geometry and selections done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    clk       = 1'b0;
    srst      = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    go        = 1'b0;
    slow      = 1'b0;
    uid       = 80'h5549_4430_3132_3334_3536;  // arbitrary id text
    failures  = 0;
    compares  = 0;
    sel       = 2'h0;
    root      = 1'b0;
    dcyl      = 16'h0400;
    dhd       = 16'h0010;
    dspt      = 16'h003f;
    ccyl      = dcyl;
    chd       = dhd;
    cspt      = dspt;
    total     = 32'h000f_c000;
    mult      = 8'h00;
    dsel      = 3'h0;
    sn        = {10{8'h20}};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_config();
    t_fields();
    close_out();
  end
endmodule
`default_nettype wire
